//--- bench/pps_pins_model.sv
// Pin-side model: resolves each port line from drive, pull and float.
// Assumes the board holds the input-only pins at fixed levels.
`timescale 1ns/10ps
module pps_pins_model #(
   parameter logic [7:0] IN_LVL = 8'hA5
) (
   // Clock
   input wire logic pclk,
   // Standard pin controls
   input wire logic [7:0] std_o,
   input wire logic [7:0] std_oe,
   input wire logic [7:0] std_pu,
   // High-voltage pin controls
   input wire logic [7:0] hv_o,
   input wire logic [7:0] hv_oe,
   input wire logic [7:0] hv_pd,
   // Line levels back to the block
   output logic [7:0] std_i,
   output logic [7:0] hv_i,
   output logic [7:0] in_i,
   output logic event_i,
   output logic vdisp_i
);
   // ****************
   // Line resolution
   // ****************
   // Undriven, unpulled lines wander so a stale level never passes
   logic flt_r = 1'b0;
   always @(posedge pclk) flt_r <= ~flt_r;
   assign std_i = (std_oe & std_o) | (~std_oe & (std_pu | {8{flt_r}}));
   assign hv_i = (hv_oe & hv_o) | (~hv_oe & ~hv_pd & {8{flt_r}});
   assign in_i = IN_LVL;
   assign event_i = 1'b1;
   assign vdisp_i = 1'b1;
endmodule : pps_pins_model

//--- bench/pps_port_ctrl_tb.sv
// Bench: reset values, then mode table through one loop, then awkward cases.
// Assumes pps_pins_model on the pins; APB driven on rising edges.
`timescale 1ns/10ps
module pps_port_ctrl_tb;
   import pps_pkg::*;
   typedef struct packed {
      logic [2:0] md;
      logic [7:0] sdir, sdat, hdir;
      logic [15:0] psel;
      logic [7:0] soe, spu, hoe, hpd, sibe, iibe;
   } pps_row_t;
   // ****************
   // Mode table
   // ****************
   localparam pps_row_t ROWS [6] = '{
      '{3'h0, 8'hA5, 8'h3C, 8'h3C, 16'h0000, 8'hA5, 8'h0F, 8'h3C, 8'h30, 8'hFF, 8'hFF},
      '{3'h1, 8'hA5, 8'h3C, 8'h3C, 16'h8381, 8'hA5, 8'h0F, 8'h3C, 8'h30, 8'h41, 8'h81},
      '{3'h2, 8'hA5, 8'h3C, 8'h3C, 16'h8381, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h41, 8'h81},
      '{3'h3, 8'hA5, 8'h3C, 8'h3C, 16'h0000, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h00},
      '{3'h4, 8'hFF, 8'h00, 8'hFF, 16'h0200, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h01, 8'h00},
      '{3'h0, 8'hFF, 8'h00, 8'hFF, 16'h0000, 8'hFF, 8'h0F, 8'hFF, 8'hF0, 8'hFF, 8'hFF}};
   logic pclk, presetn, psel, penable, pwrite, tw, pready, pslverr, err_q;
   logic event_i, vdisp_i, event_ibe, vdisp_ibe;
   logic [7:0] paddr, std_i, std_o, std_oe, std_pu, std_ibe;
   logic [7:0] hv_i, hv_o, hv_oe, hv_pd, hv_ibe, in_i, in_ibe;
   logic [31:0] pwdata, prdata, rd_q;
   pps_mode_t mode_out;
   pps_row_t r;
   int n_mismatch = 0;
   int num_checks = 0;
   pps_port_ctrl #(.STD_PU_OPT(8'h0F), .HV_PD_OPT(8'hF0), .VDISP_IS_INPUT(1'b1)) u_pps_port_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_square_wave_output(tw), .std_pin_i(std_i), .std_pin_o(std_o),
      .std_pin_oe(std_oe), .std_pu_en(std_pu), .std_ibe(std_ibe), .hv_pin_i(hv_i),
      .hv_pin_o(hv_o), .hv_pin_oe(hv_oe), .hv_pd_en(hv_pd), .hv_ibe(hv_ibe), .in_pin_i(in_i),
      .in_ibe(in_ibe), .event_pin_i(event_i), .event_ibe(event_ibe), .vdisp_pin_i(vdisp_i),
      .vdisp_ibe(vdisp_ibe), .mode_out(mode_out));
   pps_pins_model u_pps_pins_model (.pclk(pclk), .std_o(std_o), .std_oe(std_oe),
      .std_pu(std_pu), .hv_o(hv_o), .hv_oe(hv_oe), .hv_pd(hv_pd), .std_i(std_i),
      .hv_i(hv_i), .in_i(in_i), .event_i(event_i), .vdisp_i(vdisp_i));
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge; data taken there
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n < 50), 32'h1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic settle();
      repeat (2) @(negedge pclk);
   endtask : settle
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   // ****************
   // Clock, watchdog, tests
   // ****************
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #200000;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end
   initial begin
      {presetn, psel, penable, pwrite, tw, paddr, pwdata} = '0;
      repeat (8) @(negedge pclk);
      chk(32'(std_pu), 32'h0F); // reset pull-up
      chk(32'(hv_pd), 32'hF0); // reset pull-down
      chk(32'({std_oe, hv_oe}), 32'h0); // reset floats
      @(posedge pclk) presetn <= 1'b1;
      $display("test reset done");
      foreach (ROWS[i]) begin
         r = ROWS[i];
         xfer(1'b1, PPS_OFS_MODE, 32'h0);
         xfer(1'b1, PPS_OFS_STD_DIR, 32'(r.sdir));
         xfer(1'b1, PPS_OFS_STD_DAT, 32'(r.sdat));
         xfer(1'b1, PPS_OFS_HV_DIR, 32'(r.hdir));
         xfer(1'b1, PPS_OFS_HV_DAT, 32'(r.sdat));
         xfer(1'b1, PPS_OFS_PERSEL, 32'(r.psel));
         xfer(1'b1, PPS_OFS_MODE, 32'(r.md));
         settle();
         chk(32'(mode_out), 32'(r.md));
         chk(32'(std_oe), 32'(r.soe)); // drive
         chk(32'(std_o & r.soe), 32'(r.sdat & r.soe)); // held level
         chk(32'(std_pu), 32'(r.spu)); // pull-up
         chk(32'(hv_oe), 32'(r.hoe)); // drive
         chk(32'(hv_o & r.hoe), 32'(r.sdat & r.hoe)); // held level
         chk(32'(hv_pd), 32'(r.hpd)); // pull-down
         chk(32'(std_ibe & r.sibe), 32'(r.sibe)); // gates on
         chk(32'(in_ibe & r.iibe), 32'(r.iibe)); // gates
         chk(32'(hv_ibe), (r.md == 3'h0) ? 32'hFF : 32'h0); // hv gates
         $display("test row %0d done", i);
      end
      xfer(1'b1, PPS_OFS_MODE, 32'h1);
      xfer(1'b1, PPS_OFS_STD_DIR, 32'h0F);
      settle();
      chk(32'(std_oe), 32'hFF); // sleep holds drive despite dir write
      xfer(1'b1, PPS_OFS_MODE, 32'h7);
      xfer(0, PPS_OFS_MODE, 32'h0);
      chk(rd_q, 32'h1);
      xfer(1'b1, PPS_OFS_MODE, 32'h0);
      settle();
      chk(32'(std_oe), 32'h0F); // hold released
      $display("test sleep hold done");
      @(posedge pclk) tw <= 1'b1;
      xfer(1'b1, PPS_OFS_TMR, 32'h1);
      settle();
      chk(32'({std_oe[0], std_o[0]}), 32'h2); // off drives low
      xfer(1'b1, PPS_OFS_TMR, 32'h3);
      settle();
      chk(32'(std_o[0]), 32'h1);
      @(posedge pclk) tw <= 1'b0;
      settle();
      chk(32'(std_o[0]), 32'h0);
      $display("test timer done");
      xfer(1'b1, PPS_OFS_MODE, 32'h3);
      settle();
      chk(32'({vdisp_ibe, event_ibe}), 32'h0); // gated off
      xfer(0, PPS_OFS_IN_PIN, 32'h0);
      chk(rd_q, 32'h0); // not read outside active
      xfer(1'b1, PPS_OFS_MODE, 32'h0);
      settle();
      xfer(0, PPS_OFS_IN_PIN, 32'h0);
      chk(rd_q, 32'h3A5); // active readback
      chk(32'(err_q), 32'h0); // mapped read no error
      xfer(1'b1, PPS_OFS_STD_DAT, 32'h0A);
      repeat (2) settle();
      xfer(0, PPS_OFS_STD_PIN, 32'h0);
      chk(rd_q & 32'h0F, 32'h0A); // driven pins read back
      xfer(1'b1, PPS_OFS_MODE, 32'h3);
      settle();
      xfer(0, PPS_OFS_HV_PIN, 32'h0);
      chk(rd_q, 32'h0); // hv read gated off
      xfer(0, 8'h40, 32'h0);
      chk({rd_q[30:0], err_q}, 32'h1);
      $display("test inputs done");
      wrap_up();
   end
endmodule : pps_port_ctrl_tb

//--- hdl/pps_pin_cell.sv
// One pin's drive and pull decision for the current power mode.
// Assumes hold values are the pin's own registered outputs.
`timescale 1ns/10ps
module pps_pin_cell
   import pps_pkg::*;
#(
   parameter bit HV = 1'b0
) (
   // Mode and options
   input wire pps_pkg::pps_mode_t mode,
   input wire logic res_opt,
   // Register values and hold values
   input wire logic dir,
   input wire logic dat,
   input wire logic hold_oe,
   input wire logic hold_out,
   // Pin controls
   output logic oe,
   output logic out,
   output logic pu,
   output logic pd
);
   always_comb begin
      oe = 1'b0;
      out = 1'b0;
      pu = 1'b0;
      pd = 1'b0;
      case (mode)
         PPS_ACTIVE: begin
            oe = dir;
            out = dat;
            pu = !HV && res_opt;
            pd = HV && res_opt && dir;
         end
         PPS_SLEEP: begin
            oe = hold_oe;
            out = hold_out;
            pu = !HV && res_opt;
            pd = HV && res_opt && hold_oe;
         end
         default: begin
            pu = 1'b0;
            pd = HV && res_opt;
         end
      endcase
   end
endmodule : pps_pin_cell

//--- hdl/pps_pkg.sv
// Constants for the port power-state controller.
// Assumes a 32-bit APB slave on pclk and word-aligned register offsets.
package pps_pkg;
   // ****************
   // Register offsets
   // ****************
   localparam logic [7:0] PPS_OFS_MODE = 8'h00;
   localparam logic [7:0] PPS_OFS_STD_DIR = 8'h04;
   localparam logic [7:0] PPS_OFS_STD_DAT = 8'h08;
   localparam logic [7:0] PPS_OFS_HV_DIR = 8'h0C;
   localparam logic [7:0] PPS_OFS_HV_DAT = 8'h10;
   localparam logic [7:0] PPS_OFS_PERSEL = 8'h14;
   localparam logic [7:0] PPS_OFS_TMR = 8'h18;
   localparam logic [7:0] PPS_OFS_STD_PIN = 8'h1C;
   localparam logic [7:0] PPS_OFS_HV_PIN = 8'h20;
   localparam logic [7:0] PPS_OFS_IN_PIN = 8'h24;
   // ****************
   // Fields and widths
   // ****************
   localparam int PPS_PW = 8;
   localparam int PPS_SELW = 16;
   localparam int PPS_TMR_SEL_BIT = 0;
   localparam int PPS_TMR_ON_BIT = 1;
   localparam int PPS_SEL_EVENT_BIT = 8;
   localparam int PPS_SEL_STD_LSB = 9;
   // ****************
   // Power modes and reset values
   // ****************
   typedef enum logic [2:0] {
      PPS_ACTIVE, PPS_SLEEP, PPS_STANDBY, PPS_WATCH, PPS_SUBACTIVE
   } pps_mode_t;
   localparam logic [7:0] PPS_DIR_RST = 8'h00;
   localparam logic [7:0] PPS_DAT_RST = 8'h00;
   localparam logic [15:0] PPS_SEL_RST = 16'h0000;
   localparam logic [7:0] PPS_PU_OPT_DEF = 8'hFF;
   localparam logic [7:0] PPS_PD_OPT_DEF = 8'h00;
endpackage : pps_pkg

//--- hdl/pps_port_ctrl.sv
// Port power-state controller: APB registers, pin drive per power mode.
// Assumes pins are resolved outside from oe/out/pull enables; timer wave on pclk.
//
// What this block does
// - In sleep, input-configured pins are high impedance.
// - In sleep, output pins keep the level driven before sleep.
// - Standard pin pulled up where state asks, if option fitted; else floats.
// - High-voltage pins pulled down in reset and low-power modes if fitted.
// - Standard pull-ups stay on in active and sleep, whatever direction/data.
// - Standby, watch and subactive switch standard pull-ups off.
// - Peripheral-input pins except standard pin 7 keep input buffers enabled in power-down modes.
// - Display-capable pin behaviour applies only when optioned as input.
// - Each pin option is pull-up/none (standard) or pull-down/none (high-voltage).
// - Timer function selected but off drives a constant low in active mode.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
module pps_port_ctrl
   import pps_pkg::*;
#(
   parameter logic [7:0] STD_PU_OPT = pps_pkg::PPS_PU_OPT_DEF,
   parameter logic [7:0] HV_PD_OPT = pps_pkg::PPS_PD_OPT_DEF,
   parameter bit VDISP_IS_INPUT = 1'b1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer square wave, same clock
   input wire logic timer_square_wave_output,
   // Standard I/O pins
   input wire logic [pps_pkg::PPS_PW-1:0] std_pin_i,
   output logic [pps_pkg::PPS_PW-1:0] std_pin_o,
   output logic [pps_pkg::PPS_PW-1:0] std_pin_oe,
   output logic [pps_pkg::PPS_PW-1:0] std_pu_en,
   output logic [pps_pkg::PPS_PW-1:0] std_ibe,
   // High-voltage I/O pins
   input wire logic [pps_pkg::PPS_PW-1:0] hv_pin_i,
   output logic [pps_pkg::PPS_PW-1:0] hv_pin_o,
   output logic [pps_pkg::PPS_PW-1:0] hv_pin_oe,
   output logic [pps_pkg::PPS_PW-1:0] hv_pd_en,
   output logic [pps_pkg::PPS_PW-1:0] hv_ibe,
   // Input-only pins
   input wire logic [pps_pkg::PPS_PW-1:0] in_pin_i,
   output logic [pps_pkg::PPS_PW-1:0] in_ibe,
   input wire logic event_pin_i,
   output logic event_ibe,
   input wire logic vdisp_pin_i,
   output logic vdisp_ibe,
   // Mode seen by the pins
   output pps_pkg::pps_mode_t mode_out
);
   import pps_pkg::*;

   // ****************
   // Registers
   // ****************
   pps_mode_t mode_r;
   logic [7:0] std_dir_r, std_dat_r, hv_dir_r, hv_dat_r;
   logic [15:0] persel_r;
   logic [1:0] tmr_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic [7:0] std_o_r, std_oe_r, std_pu_r, std_ibe_r;
   logic [7:0] hv_o_r, hv_oe_r, hv_pd_r, hv_ibe_r;
   logic [7:0] in_ibe_r;
   logic event_ibe_r, vdisp_ibe_r;
   logic [7:0] std_s1, std_s2, hv_s1, hv_s2, in_s1, in_s2;
   logic [1:0] ev_s1, ev_s2;

   // ****************
   // APB decode
   // ****************
   wire setup = psel && !penable;
   wire wr_en = psel && penable && pready_r && pwrite;
   wire hit_mode = paddr == PPS_OFS_MODE;
   wire hit_sdir = paddr == PPS_OFS_STD_DIR;
   wire hit_sdat = paddr == PPS_OFS_STD_DAT;
   wire hit_hdir = paddr == PPS_OFS_HV_DIR;
   wire hit_hdat = paddr == PPS_OFS_HV_DAT;
   wire hit_sel = paddr == PPS_OFS_PERSEL;
   wire hit_tmr = paddr == PPS_OFS_TMR;
   wire hit_spin = paddr == PPS_OFS_STD_PIN;
   wire hit_hpin = paddr == PPS_OFS_HV_PIN;
   wire hit_ipin = paddr == PPS_OFS_IN_PIN;
   wire mapped = hit_mode | hit_sdir | hit_sdat | hit_hdir | hit_hdat | hit_sel
      | hit_tmr | hit_spin | hit_hpin | hit_ipin;
   wire is_active = mode_r == PPS_ACTIVE;
   // Pin readback only through enabled input buffers
   wire [7:0] std_rd = std_s2 & std_ibe_r;
   wire [7:0] hv_rd = hv_s2 & hv_ibe_r;
   wire [9:0] in_rd = {ev_s2[1] & vdisp_ibe_r, ev_s2[0] & event_ibe_r, in_s2 & in_ibe_r};
   logic [31:0] rd_mux;
   always_comb begin
      if (hit_mode) rd_mux = {29'h0, mode_r};
      else if (hit_sdir) rd_mux = {24'h0, std_dir_r};
      else if (hit_sdat) rd_mux = {24'h0, std_dat_r};
      else if (hit_hdir) rd_mux = {24'h0, hv_dir_r};
      else if (hit_hdat) rd_mux = {24'h0, hv_dat_r};
      else if (hit_sel) rd_mux = {16'h0, persel_r};
      else if (hit_tmr) rd_mux = {30'h0, tmr_r};
      else if (hit_spin) rd_mux = {24'h0, std_rd};
      else if (hit_hpin) rd_mux = {24'h0, hv_rd};
      else if (hit_ipin) rd_mux = {22'h0, in_rd};
      else rd_mux = 32'h0;
   end
   wire [2:0] mode_wr = pwdata[2:0];
   wire mode_ok = mode_wr <= 3'h4;

   // Answer one cycle after setup; unmapped gives pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !mapped;
         prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= PPS_ACTIVE;
         std_dir_r <= PPS_DIR_RST;
         std_dat_r <= PPS_DAT_RST;
         hv_dir_r <= PPS_DIR_RST;
         hv_dat_r <= PPS_DAT_RST;
         persel_r <= PPS_SEL_RST;
         tmr_r <= 2'h0;
      end else if (wr_en) begin
         // Undefined mode codes are ignored
         if (hit_mode && mode_ok) mode_r <= pps_mode_t'(mode_wr);
         if (hit_sdir) std_dir_r <= pwdata[7:0];
         if (hit_sdat) std_dat_r <= pwdata[7:0];
         if (hit_hdir) hv_dir_r <= pwdata[7:0];
         if (hit_hdat) hv_dat_r <= pwdata[7:0];
         if (hit_sel) persel_r <= pwdata[15:0];
         if (hit_tmr) tmr_r <= pwdata[1:0];
      end
   end

   // ****************
   // Pin synchronisers
   // ****************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {std_s1, std_s2, hv_s1, hv_s2, in_s1, in_s2} <= '0;
         {ev_s1, ev_s2} <= '0;
      end else begin
         std_s1 <= std_pin_i;
         std_s2 <= std_s1;
         hv_s1 <= hv_pin_i;
         hv_s2 <= hv_s1;
         in_s1 <= in_pin_i;
         in_s2 <= in_s1;
         ev_s1 <= {vdisp_pin_i, event_pin_i};
         ev_s2 <= ev_s1;
      end
   end

   // ****************
   // Pin control
   // ****************
   // timer pin off drives low
   wire [7:0] std_dir_eff = tmr_r[PPS_TMR_SEL_BIT] ? (std_dir_r | 8'h01) : std_dir_r;
   wire tmr_lvl = tmr_r[PPS_TMR_ON_BIT] & timer_square_wave_output;
   wire [7:0] std_dat_eff = tmr_r[PPS_TMR_SEL_BIT] ? {std_dat_r[7:1], tmr_lvl} : std_dat_r;
   wire [7:0] std_oe_n, std_o_n, std_pu_n, hv_oe_n, hv_o_n, hv_pd_n;
   // Only seven select bits fit above the event bit; pin 7 has none
   wire [7:0] std_sel = {1'b0, persel_r[PPS_SELW-1:PPS_SEL_STD_LSB]};

   genvar i;
   generate
      for (i = 0; i < PPS_PW; i++) begin : g_pin
         // one option bit per pin, pull kind by pin type
         pps_pin_cell #(.HV(1'b0)) u_std (
            .mode(mode_r), .res_opt(STD_PU_OPT[i]), .dir(std_dir_eff[i]),
            .dat(std_dat_eff[i]), .hold_oe(std_oe_r[i]), .hold_out(std_o_r[i]),
            .oe(std_oe_n[i]), .out(std_o_n[i]), .pu(std_pu_n[i]), .pd()
         );
         pps_pin_cell #(.HV(1'b1)) u_hv (
            .mode(mode_r), .res_opt(HV_PD_OPT[i]), .dir(hv_dir_r[i]),
            .dat(hv_dat_r[i]), .hold_oe(hv_oe_r[i]), .hold_out(hv_o_r[i]),
            .oe(hv_oe_n[i]), .out(hv_o_n[i]), .pu(), .pd(hv_pd_n[i])
         );
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         std_pu_r <= STD_PU_OPT;
         hv_pd_r <= HV_PD_OPT;
         {std_o_r, std_oe_r, hv_o_r, hv_oe_r} <= '0;
         {std_ibe_r, hv_ibe_r, in_ibe_r} <= '0;
         {event_ibe_r, vdisp_ibe_r} <= 2'h0;
      end else begin
         std_o_r <= std_o_n;
         std_oe_r <= std_oe_n;
         std_pu_r <= std_pu_n;
         hv_o_r <= hv_o_n;
         hv_oe_r <= hv_oe_n;
         hv_pd_r <= hv_pd_n;
         std_ibe_r <= {8{is_active}} | std_sel;
         hv_ibe_r <= {8{is_active}};
         // input port live in active, or per bit where persel_r[7:0] selects it
         in_ibe_r <= {8{is_active}} | persel_r[7:0];
         event_ibe_r <= is_active | persel_r[PPS_SEL_EVENT_BIT];
         // gated input only when optioned so
         vdisp_ibe_r <= VDISP_IS_INPUT && is_active;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign {std_pin_o, std_pin_oe, std_pu_en, std_ibe} = {std_o_r, std_oe_r, std_pu_r, std_ibe_r};
   assign {hv_pin_o, hv_pin_oe, hv_pd_en, hv_ibe} = {hv_o_r, hv_oe_r, hv_pd_r, hv_ibe_r};
   assign in_ibe = in_ibe_r;
   assign event_ibe = event_ibe_r;
   assign vdisp_ibe = vdisp_ibe_r;
   assign mode_out = mode_r;

   // ****************
   // Assertions
   // ****************
   wire low_pwr = mode_r inside {PPS_STANDBY, PPS_WATCH, PPS_SUBACTIVE};
   property p_sleep_in_hiz;
      @(posedge pclk) disable iff (!presetn)
      $past(mode_r) == PPS_SLEEP && mode_r == PPS_SLEEP && !$past(std_oe_r[1])
         |-> !std_oe_r[1];
   endproperty
   a_sleep_in_hiz: assert property (p_sleep_in_hiz) else $error("Sleep input drove");
   property p_sleep_hold;
      @(posedge pclk) disable iff (!presetn)
      mode_r == PPS_SLEEP ##1 mode_r == PPS_SLEEP |-> $stable(hv_o_r) && $stable(hv_oe_r);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("Sleep output moved");
   property p_pu_opt;
      @(posedge pclk) disable iff (!presetn) (std_pu_r & ~STD_PU_OPT) == 8'h00;
   endproperty
   a_pu_opt: assert property (p_pu_opt) else $error("Pull-up without option");
   property p_hv_pd;
      @(posedge pclk) disable iff (!presetn)
      low_pwr ##1 low_pwr |-> hv_pd_r == HV_PD_OPT && hv_oe_r == 8'h00;
   endproperty
   a_hv_pd: assert property (p_hv_pd) else $error("High-voltage pull wrong");
   property p_pu_on;
      @(posedge pclk) disable iff (!presetn)
      mode_r == PPS_ACTIVE ##1 mode_r == PPS_ACTIVE |-> std_pu_r == STD_PU_OPT;
   endproperty
   a_pu_on: assert property (p_pu_on) else $error("Active pull-up off");
   property p_pu_off;
      @(posedge pclk) disable iff (!presetn)
      low_pwr ##1 low_pwr |-> std_pu_r == 8'h00 && std_oe_r == 8'h00;
   endproperty
   a_pu_off: assert property (p_pu_off) else $error("Low-power pull-up on");
   property p_per_ibe;
      @(posedge pclk) disable iff (!presetn)
      persel_r[PPS_SEL_EVENT_BIT] |=> event_ibe_r;
   endproperty
   a_per_ibe: assert property (p_per_ibe) else $error("Peripheral input gated");
   property p_in_gate;
      @(posedge pclk) disable iff (!presetn)
      !is_active && persel_r[7:0] == 8'h00 |=> in_ibe_r == 8'h00;
   endproperty
   a_in_gate: assert property (p_in_gate) else $error("Input port open");
   property p_tmr_low;
      @(posedge pclk) disable iff (!presetn)
      is_active && tmr_r == 2'h1 |=> std_oe_r[0] && !std_o_r[0];
   endproperty
   a_tmr_low: assert property (p_tmr_low) else $error("Timer pin not low");
   property p_apb_wait;
      @(posedge pclk) disable iff (!presetn) setup |=> pready_r;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("APB answer late");
   c_sleep: cover property (@(posedge pclk) disable iff (!presetn)
      mode_r == PPS_ACTIVE ##1 mode_r == PPS_SLEEP);
   c_standby: cover property (@(posedge pclk) disable iff (!presetn)
      mode_r == PPS_STANDBY);
   c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr_r);
   c_tmr: cover property (@(posedge pclk) disable iff (!presetn) tmr_r == 2'h3);
endmodule : pps_port_ctrl
